// ---- hw/pxs_pkg.sv ----
package pxs_pkg;

  // Bus address of the sensor and the direction bit values.
  localparam logic [6:0] SLAVE_ID_BITS = 7'h55;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic       DIR_READ      = 1'h1;

  // Bit positions inside the address byte.
  localparam int unsigned ID_MSB  = 7;
  localparam int unsigned ID_LSB  = 1;
  localparam int unsigned DIR_POS = 0;

  // Bits per byte; the acknowledge is the pulse after the last one.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Host clock and serial clock timing.
  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int unsigned SCL_HZ  = 100_000;
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0]  QTR_MAX = 8'(QTR_CYC - 1);

  // Host byte slots within one transaction.
  localparam logic [1:0] SLOT_ADDR = 2'h0;
  localparam logic [1:0] SLOT_REG  = 2'h1;
  localparam logic [1:0] SLOT_DATA = 2'h2;
  localparam logic [1:0] SLOT_ADRD = 2'h2;
  localparam logic [1:0] SLOT_RX   = 2'h3;

endpackage : pxs_pkg

// ---- hw/pxs_link_if.sv ----
`timescale 1ns/1ps
interface pxs_link_if;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sda;

  // Open drain with pull-up: any enabled low driver wins.
  assign sda = (sdaHostOe ? sdaHostOut : 1'b1) &
               (sdaDevOe ? sdaDevOut : 1'b1);

  modport host (output scl, output sdaHostOut, output sdaHostOe,
                input sda);
  modport dev  (input scl, input sda, output sdaDevOut,
                output sdaDevOe);
endinterface : pxs_link_if

// ---- hw/pxs_sync.sv ----
`timescale 1ns/1ps
module pxs_sync (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);

  // Three stages per line; the output moves only when the last two agree.
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : gLine
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;
      logic q_nxt;
      always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
      end
      always_ff @(posedge clk) begin
        if (!rstn) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          q_r  <= 1'b1;
        end else begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          q_r  <= q_nxt;
        end
      end
      assign dout[i] = q_r;
    end
  endgenerate

endmodule : pxs_sync

// ---- hw/pxs_dev.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Answer only to slave id 1010101.
// - Address LSB zero writes, one reads.
// - Sample SDA while SCL stays high.
// - Master keeps SDA high when idle.
// - SDA falling with SCL high starts compare.
// - Master sends address byte MSB first.
// - Master releases SDA, pulses SCL for acknowledge.
// - Matching address gets SDA held low.
// - Missing acknowledge makes master stop, abandon.
// - Register address byte follows, MSB first.
// - Register address byte acknowledged on ninth pulse.
// - Data byte follows, MSB first.
// - Data byte acknowledged with SDA low.
// - SDA rising with SCL high ends transfer.
// - Read: write register, repeated start, read.
module pxs_dev (
  input  wire logic       linkClk,
  input  wire logic       rstn,
  pxs_link_if.dev         link,
  input  wire logic       userWe,
  input  wire logic [7:0] userAddr,
  input  wire logic [7:0] userData,
  output logic            busWrPulse,
  output logic      [7:0] busWrAddr,
  output logic      [7:0] busWrData
);

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK
  } pxs_dst_t;

  // The whole engine runs on the link clock, which must be several times
  // faster than SCL so that both bus lines are seen to change in order.
  logic [1:0] pins;
  logic       scl;
  logic       sda;

  pxs_sync uSync (
    .clk  (linkClk),
    .rstn (rstn),
    .din  ({link.scl, link.sda}),
    .dout (pins)
  );
  assign scl = pins[1];
  assign sda = pins[0];

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:255];

  pxs_dst_t   st_r;
  pxs_dst_t   st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       wrPulse_r;
  logic       wrPulse_nxt;
  logic [7:0] wrAddr_r;
  logic [7:0] wrAddr_nxt;
  logic [7:0] wrData_r;
  logic [7:0] wrData_nxt;
  logic       out_r;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  always_comb begin
    sclRise   = scl & ~sclPrev_r;
    sclFall   = ~scl & sclPrev_r;
    startSeen = scl & sclPrev_r & sdaPrev_r & ~sda;
    stopSeen  = scl & sclPrev_r & ~sdaPrev_r & sda;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    ptr_nxt     = ptr_r;
    oe_nxt      = oe_r;
    wrPulse_nxt = 1'b0;
    wrAddr_nxt  = wrAddr_r;
    wrData_nxt  = wrData_r;
    if (startSeen) begin
      // A repeated start lands here too and restarts the compare.
      st_nxt  = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stopSeen) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_REG, ST_DATA: begin
          if (sclRise) begin
            sh_nxt  = {sh_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
          end else if (sclFall && cnt_r == pxs_pkg::BYTE_BITS) begin
            cnt_nxt = 4'h0;
            if (st_r == ST_ADDR) begin
              if (sh_r[pxs_pkg::ID_MSB:pxs_pkg::ID_LSB] ==
                  pxs_pkg::SLAVE_ID_BITS) begin
                st_nxt = ST_ADDR_ACK;
                oe_nxt = 1'b1;
              end else begin
                st_nxt = ST_IDLE;
              end
            end else if (st_r == ST_REG) begin
              st_nxt  = ST_REG_ACK;
              ptr_nxt = sh_r;
              oe_nxt  = 1'b1;
            end else begin
              st_nxt      = ST_DATA_ACK;
              oe_nxt      = 1'b1;
              wrPulse_nxt = 1'b1;
              wrAddr_nxt  = ptr_r;
              wrData_nxt  = sh_r;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (sh_r[pxs_pkg::DIR_POS] == pxs_pkg::DIR_READ) begin
              // Send the selected register, first bit right away.
              st_nxt  = ST_TX;
              sh_nxt  = mem[ptr_r];
              oe_nxt  = ~mem[ptr_r][7];
              cnt_nxt = 4'h0;
            end else begin
              st_nxt = ST_REG;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_REG_ACK, ST_DATA_ACK: begin
          if (sclFall) begin
            // Further data bytes go to the following registers.
            st_nxt = ST_DATA;
            oe_nxt = 1'b0;
            if (st_r == ST_DATA_ACK) begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        ST_TX: begin
          if (sclRise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (sclFall) begin
            if (cnt_r == pxs_pkg::BYTE_BITS) begin
              st_nxt  = ST_TX_ACK;
              oe_nxt  = 1'b0;
              cnt_nxt = 4'h0;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        ST_TX_ACK: begin
          // A master that does not acknowledge gets no more bytes.
          if (sclRise) begin
            if (sda) begin
              st_nxt = ST_IDLE;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end else if (sclFall) begin
            st_nxt = ST_TX;
            sh_nxt = mem[ptr_r];
            oe_nxt = ~mem[ptr_r][7];
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge linkClk) begin
    if (!rstn) begin
      st_r      <= ST_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= pxs_pkg::BYTE_RST;
      ptr_r     <= pxs_pkg::BYTE_RST;
      oe_r      <= 1'b0;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      wrPulse_r <= 1'b0;
      wrAddr_r  <= pxs_pkg::BYTE_RST;
      wrData_r  <= pxs_pkg::BYTE_RST;
      out_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      ptr_r     <= ptr_nxt;
      oe_r      <= oe_nxt;
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
      wrPulse_r <= wrPulse_nxt;
      wrAddr_r  <= wrAddr_nxt;
      wrData_r  <= wrData_nxt;
      out_r     <= 1'b0;
    end
  end

  // The register array has no reset; the bus write wins over the user port.
  always_ff @(posedge linkClk) begin
    if (wrPulse_nxt) begin
      mem[wrAddr_nxt] <= wrData_nxt;
    end else if (userWe) begin
      mem[userAddr] <= userData;
    end
  end

  assign link.sdaDevOut = out_r;
  assign link.sdaDevOe  = oe_r;
  assign busWrPulse     = wrPulse_r;
  assign busWrAddr      = wrAddr_r;
  assign busWrData      = wrData_r;

endmodule : pxs_dev

// ---- hw/pxs_host.sv ----
`timescale 1ns/1ps
module pxs_host (
  input  wire logic       clk,
  input  wire logic       rstn,
  pxs_link_if.host        link,
  input  wire logic       cmdValid,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdReg,
  input  wire logic [7:0] cmdData,
  output logic            cmdReady,
  output logic            doneValid,
  output logic            doneNack,
  output logic      [7:0] doneData
);

  typedef enum {HS_IDLE, HS_START, HS_SHIFT, HS_STOP} pxs_hst_t;

  // Byte sent in a given slot of the transaction.
  function automatic logic [7:0] slotByte(input logic [1:0] slot,
                                          input logic       rd,
                                          input logic [7:0] rg,
                                          input logic [7:0] dt);
    if (slot == pxs_pkg::SLOT_ADDR)
      slotByte = {pxs_pkg::SLAVE_ID_BITS, pxs_pkg::DIR_WRITE};
    else if (slot == pxs_pkg::SLOT_REG)
      slotByte = rg;
    else if (rd)
      slotByte = {pxs_pkg::SLAVE_ID_BITS, pxs_pkg::DIR_READ};
    else
      slotByte = dt;
  endfunction : slotByte

  logic [1:0] pins;
  logic       sda;

  pxs_sync uSync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({1'b1, link.sda}),
    .dout (pins)
  );
  assign sda = pins[0];

  ////////////////////////////////////////////////////////////////////////////
  pxs_hst_t   st_r;
  pxs_hst_t   st_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic [1:0] slot_r;
  logic [1:0] slot_nxt;
  logic       rd_r;
  logic       rd_nxt;
  logic [7:0] reg_r;
  logic [7:0] reg_nxt;
  logic [7:0] dat_r;
  logic [7:0] dat_nxt;
  logic [7:0] tx;
  logic       scl_r;
  logic       scl_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       nack_r;
  logic       nack_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       rx;
  logic       tick;

  always_comb begin
    tick     = (div_r == pxs_pkg::QTR_MAX);
    rx       = rd_r && slot_r == pxs_pkg::SLOT_RX;
    tx       = slotByte(slot_r, rd_r, reg_r, dat_r);
    st_nxt   = st_r;
    div_nxt  = (st_r == HS_IDLE || tick) ? 8'h00 : div_r + 8'h01;
    ph_nxt   = tick ? ph_r + 2'h1 : ph_r;
    bit_nxt  = bit_r;
    slot_nxt = slot_r;
    rd_nxt   = rd_r;
    reg_nxt  = reg_r;
    dat_nxt  = dat_r;
    scl_nxt  = scl_r;
    oe_nxt   = oe_r;
    nack_nxt = nack_r;
    done_nxt = 1'b0;
    case (st_r)
      HS_IDLE: begin
        scl_nxt = 1'b1;
        oe_nxt  = 1'b0;
        ph_nxt  = 2'h0;
        if (cmdValid) begin
          st_nxt   = HS_START;
          rd_nxt   = cmdRead;
          reg_nxt  = cmdReg;
          dat_nxt  = cmdData;
          slot_nxt = pxs_pkg::SLOT_ADDR;
          nack_nxt = 1'b0;
        end
      end
      HS_START: begin
        // Release, raise SCL, pull SDA, drop SCL; also a repeated start.
        if (tick) begin
          case (ph_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: oe_nxt = 1'b1;
            2'h2: scl_nxt = 1'b0;
            default: begin
              st_nxt  = HS_SHIFT;
              bit_nxt = 4'h0;
            end
          endcase
        end else if (ph_r == 2'h0 && div_r == 8'h00) begin
          oe_nxt = 1'b0;
        end
      end
      HS_SHIFT: begin
        if (tick) begin
          case (ph_r)
            2'h0: begin
              if (bit_r == pxs_pkg::BYTE_BITS || rx)
                oe_nxt = 1'b0;
              else
                oe_nxt = ~tx[3'(7 - bit_r)];
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: begin
              if (bit_r != pxs_pkg::BYTE_BITS && rx)
                dat_nxt = {dat_r[6:0], sda};
              else if (bit_r == pxs_pkg::BYTE_BITS && !rx)
                nack_nxt = sda;
            end
            default: begin
              scl_nxt = 1'b0;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == pxs_pkg::BYTE_BITS) begin
                bit_nxt  = 4'h0;
                slot_nxt = slot_r + 2'h1;
                if (nack_r || rx ||
                    (!rd_r && slot_r == pxs_pkg::SLOT_DATA))
                  st_nxt = HS_STOP;
                else if (rd_r && slot_r == pxs_pkg::SLOT_REG)
                  st_nxt = HS_START;
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          case (ph_r)
            2'h0: oe_nxt = 1'b1;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b0;
            default: begin
              st_nxt   = HS_IDLE;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r   <= HS_IDLE;
      div_r  <= 8'h00;
      ph_r   <= 2'h0;
      bit_r  <= 4'h0;
      slot_r <= pxs_pkg::SLOT_ADDR;
      rd_r   <= 1'b0;
      reg_r  <= pxs_pkg::BYTE_RST;
      dat_r  <= pxs_pkg::BYTE_RST;
      scl_r  <= 1'b1;
      oe_r   <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      ph_r   <= ph_nxt;
      bit_r  <= bit_nxt;
      slot_r <= slot_nxt;
      rd_r   <= rd_nxt;
      reg_r  <= reg_nxt;
      dat_r  <= dat_nxt;
      scl_r  <= scl_nxt;
      oe_r   <= oe_nxt;
      nack_r <= nack_nxt;
      done_r <= done_nxt;
    end
  end

  logic ready_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (st_nxt == HS_IDLE);
    end
  end

  assign link.scl        = scl_r;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = oe_r;
  assign cmdReady        = ready_r;
  assign doneValid       = done_r;
  assign doneNack        = nack_r;
  assign doneData        = dat_r;

endmodule : pxs_host

// ---- sim/pxs_link_properties.sv ----
`timescale 1ns/1ps
module pxs_link_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaHostOe,
  input wire logic sdaDevOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic       sclQ_r, sclQ_nxt;
  logic       sdaQ_r, sdaQ_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [1:0] byteIdx_r, byteIdx_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic       dirRd_r, dirRd_nxt;
  logic [7:0] hiCnt_r, hiCnt_nxt;
  logic       sclRise;
  logic       ackRise;
  logic       startEv;

  assign sclRise = scl & ~sclQ_r;
  assign ackRise = sclRise & (bitCnt_r == 4'h8);
  assign startEv = scl & sclQ_r & sdaQ_r & ~sda;

  // Bus position is tracked from the wire alone, so the figures checked
  // below do not lean on anything inside either end.
  always_comb begin
    sclQ_nxt    = scl;
    sdaQ_nxt    = sda;
    bitCnt_nxt  = bitCnt_r;
    byteIdx_nxt = byteIdx_r;
    shift_nxt   = shift_r;
    dirRd_nxt   = dirRd_r;
    hiCnt_nxt   = 8'h00;
    if (scl) begin
      hiCnt_nxt = (hiCnt_r == 8'hff) ? hiCnt_r : hiCnt_r + 8'h01;
    end
    if (startEv) begin
      bitCnt_nxt  = 4'h0;
      byteIdx_nxt = 2'h0;
    end else if (ackRise) begin
      bitCnt_nxt  = 4'h0;
      byteIdx_nxt = (byteIdx_r == 2'h3) ? byteIdx_r : byteIdx_r + 2'h1;
    end else if (sclRise) begin
      bitCnt_nxt = bitCnt_r + 4'h1;
      shift_nxt  = {shift_r[6:0], sda};
      if (byteIdx_r == 2'h0 && bitCnt_r == 4'h7) begin
        dirRd_nxt = sda;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclQ_r    <= 1'b1;
      sdaQ_r    <= 1'b1;
      bitCnt_r  <= 4'h0;
      byteIdx_r <= 2'h0;
      shift_r   <= 8'h00;
      dirRd_r   <= 1'b0;
      hiCnt_r   <= 8'h00;
    end else begin
      sclQ_r    <= sclQ_nxt;
      sdaQ_r    <= sdaQ_nxt;
      bitCnt_r  <= bitCnt_nxt;
      byteIdx_r <= byteIdx_nxt;
      shift_r   <= shift_nxt;
      dirRd_r   <= dirRd_nxt;
      hiCnt_r   <= hiCnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence startSeq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $past(scl) && $rose(sda);
  endsequence

  addr_ack_a:
    assert property (ackRise && byteIdx_r == 2'h0
      |-> sda == (shift_r[7:1] != pxs_pkg::SLAVE_ID_BITS))
    else $error("address acknowledge wrong");
  byte_ack_a:
    assert property (ackRise && byteIdx_r != 2'h0 && !dirRd_r |-> !sda)
    else $error("written byte not acknowledged");
  read_nack_a:
    assert property (ackRise && byteIdx_r != 2'h0 && dirRd_r |-> sda)
    else $error("read byte not closed by release");
  ack_release_a:
    assert property (ackRise |-> !sdaHostOe)
    else $error("host holds data line in acknowledge slot");
  host_stable_a:
    assert property ($rose(scl) |-> $stable(sdaHostOe) [*8])
    else $error("host data moved while clock high");
  dev_stable_a:
    assert property (scl && $past(scl) |-> $stable(sdaDevOe))
    else $error("device data moved while clock high");
  start_hold_a:
    assert property (startSeq |-> scl [*8])
    else $error("clock dropped right after start");
  stop_idle_a:
    assert property (stopSeq |-> !sdaDevOe [*8])
    else $error("device drives after stop");
  idle_high_a:
    assert property (hiCnt_r == 8'hc8 |-> sda && !sdaHostOe && !sdaDevOe)
    else $error("data line low on idle bus");
endmodule : pxs_link_properties

// ---- sim/tb_proximity_sensor_i2c_slave.sv ----
`timescale 1ns/1ps
module tb_proximity_sensor_i2c_slave;
  logic        clk = 1'b0;
  logic        linkClk = 1'b0;
  logic        rstn = 1'b0;
  logic        linkRstn = 1'b0;
  logic [1:0]  cmdValid = 2'h0;
  logic        cmdRead = 1'b0;
  logic [7:0]  cmdReg = 8'h00;
  logic [7:0]  cmdData = 8'h00;
  logic        userWe = 1'b0;
  logic [7:0]  userAddr = 8'h00;
  logic [7:0]  userData = 8'h00;
  logic [1:0]  ready;
  logic [1:0]  doneValid;
  logic [1:0]  doneNack;
  logic [7:0]  doneData [2];
  logic        busWrPulse;
  logic [7:0]  busWrAddr;
  logic [7:0]  busWrData;
  logic [7:0]  mem [256];
  logic [31:0] seed = 32'hbcc9;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          wrCnt = 0;
  int          lastWait = 0;

  // The second link has no device on it, so every address goes unanswered.
  pxs_link_if lnk ();
  pxs_link_if lnkBad ();
  assign lnkBad.sdaDevOut = 1'b0;
  assign lnkBad.sdaDevOe  = 1'b0;

  pxs_host u_pxs_host (.clk (clk), .rstn (rstn), .link (lnk),
    .cmdValid (cmdValid[0]), .cmdRead (cmdRead), .cmdReg (cmdReg),
    .cmdData (cmdData), .cmdReady (ready[0]), .doneValid (doneValid[0]),
    .doneNack (doneNack[0]), .doneData (doneData[0]));
  pxs_host u_pxs_host_bad (.clk (clk), .rstn (rstn), .link (lnkBad),
    .cmdValid (cmdValid[1]), .cmdRead (cmdRead), .cmdReg (cmdReg),
    .cmdData (cmdData), .cmdReady (ready[1]), .doneValid (doneValid[1]),
    .doneNack (doneNack[1]), .doneData (doneData[1]));
  pxs_dev u_pxs_dev (.linkClk (linkClk), .rstn (linkRstn), .link (lnk),
    .userWe (userWe), .userAddr (userAddr), .userData (userData),
    .busWrPulse (busWrPulse), .busWrAddr (busWrAddr),
    .busWrData (busWrData));
  pxs_link_properties u_pxs_link_properties (.clk (clk), .rstn (rstn),
    .scl (lnk.scl), .sda (lnk.sda), .sdaHostOe (lnk.sdaHostOe),
    .sdaDevOe (lnk.sdaDevOe));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #7;
    forever #15 linkClk = ~linkClk;
  end
  always @(posedge linkClk) begin
    linkRstn <= rstn;
    if (busWrPulse === 1'b1) wrCnt <= wrCnt + 1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs

  function automatic logic [7:0] expRd(input logic [7:0] a);
    return mem[a];
  endfunction : expRd

  task automatic check(input string nm, input logic [7:0] got,
                       input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic xfer(input int h, input logic rd, input logic [7:0] rg,
                      input logic [7:0] dt);
    do begin
      @(posedge clk);
      #1;
    end while (ready[h] !== 1'b1);
    cmdValid[h] = 1'b1;
    cmdRead = rd;
    cmdReg = rg;
    cmdData = dt;
    @(posedge clk);
    #1;
    cmdValid[h] = 1'b0;
    lastWait = 0;
    while (doneValid[h] !== 1'b1 && lastWait < 9000) begin
      @(posedge clk);
      #1;
      lastWait++;
    end
    if (lastWait == 9000) mismatches++;
  endtask : xfer

  task automatic wr(input logic [7:0] rg, input logic [7:0] dt);
    int w0;
    w0 = wrCnt;
    xfer(0, 1'b0, rg, dt);
    mem[rg] = dt;
    check("write nack", {7'h00, doneNack[0]}, 8'h00);
    check("stored reg", busWrAddr, rg);
    check("stored data", busWrData, dt);
    check("write pulses", 8'(wrCnt - w0), 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] rg);
    xfer(0, 1'b1, rg, 8'h00);
    check("read nack", {7'h00, doneNack[0]}, 8'h00);
    check("read data", doneData[0], expRd(rg));
  endtask : rd

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    logic [7:0] regs [6];
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    regs = '{8'h00, 8'hff, xs(), xs(), xs(), xs()};
    foreach (regs[i]) wr(regs[i], (i < 2) ? {8{i[0]}} : xs());
    $display("test write done");
    for (int i = 5; i >= 0; i--) rd(regs[i]);
    $display("test read done");
    // Leave the bus at rest for a while, so that the idle check in the
    // checker sees a long spell of clock high between transfers.
    repeat (250) @(posedge clk);
    #1;
    @(posedge linkClk);
    #1;
    userWe = 1'b1;
    userAddr = xs() | 8'h80;
    userData = xs();
    @(posedge linkClk);
    #1;
    userWe = 1'b0;
    mem[userAddr] = userData;
    rd(userAddr);
    $display("test local write done");
    // A full write needs about 2900 cycles; an early stop needs far fewer.
    xfer(1, 1'b0, xs(), xs());
    check("missing ack", {7'h00, doneNack[1]}, 8'h01);
    check("abort early", {7'h00, lastWait < 1300}, 8'h01);
    check("bus free", {6'h00, lnkBad.scl, lnkBad.sda}, 8'h03);
    $display("test abort done");
    end_sim();
  end
endmodule : tb_proximity_sensor_i2c_slave
